// ### dv/cpu_core_model.sv
// cpu core stand-in: one address per cycle to both spaces, plus memory bytes
// assumes the bench hands it the address it wants
`timescale 1ns/1ps
module cpu_core_model (
	input  wire logic        aclk,
	input  wire logic [15:0] addr_req,
	output logic      [15:0] data_addr,
	output logic      [15:0] code_addr,
	output wire logic [7:0]  boot_rdata,
	output wire logic [7:0]  other_rdata
);
	// passes on any address the bench asks for, peripheral bytes included
	always @(posedge aclk) begin
		data_addr <= addr_req;
		code_addr <= addr_req;
	end
	// bytes follow the address so a stale or uncleared byte cannot pass
	assign boot_rdata  = data_addr[7:0] ^ 8'h5a;
	assign other_rdata = data_addr[15:8];
endmodule

// ### dv/data_area_address_map_monitor.sv
// checker on the decoder outputs
// assumes it is bound to the decoder top and sees only its ports
`timescale 1ns/1ps
module data_area_address_map_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [15:0] data_addr,
	input wire logic [15:0] code_addr,
	input wire logic [7:0]  boot_rdata,
	input wire logic [2:0]  data_target,
	input wire logic [2:0]  code_target,
	input wire logic [10:0] boot_offset,
	input wire logic [7:0]  data_rdata,
	input wire logic        boot_mapped
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// boot window hit, shared by the boot checks
	wire win = data_addr[15:11] == 5'h02;
	AST_PERI: assert property (data_addr < 16'h0040 |=> data_target == 3'h1)
		else $error("peripheral");
	AST_RAM: assert property (data_addr inside {[16'h0040:16'h083f]} |=> data_target == 3'h2)
		else $error("ram");
	AST_FLASH: assert property (data_addr[15] |=> data_target == 3'h4) else $error("flash");
	AST_CODE: assert property (code_addr[15] |=> code_target == 3'h4) else $error("code");
	AST_BOOT: assert property (win ##1 boot_mapped |->
		data_target == 3'h3 && data_rdata == $past(boot_rdata)) else $error("boot");
	// boot_mapped lags the active copy a cycle, so it is read one cycle after the address
	AST_FF: assert property (win ##1 !boot_mapped |->
		data_rdata == 8'hff && data_target == 3'h0) else $error("unmapped");
	AST_OFS: assert property (win |=> {5'h02, boot_offset} == $past(data_addr))
		else $error("offset");
	AST_RST: assert property ($rose(aresetn) |-> !boot_mapped) else $error("reset map");
endmodule
bind data_area_address_map data_area_address_map_monitor u_mon (.aclk, .aresetn, .data_addr,
	.code_addr, .boot_rdata, .data_target, .code_target, .boot_offset, .data_rdata, .boot_mapped);

// ### dv/testbench.sv
// bench: register access over axi4-lite and decode checks
// assumes the decoder, the cpu core model and the bound checker
`timescale 1ns/1ps
module testbench;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, boot_mapped;
	logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] addr_req = 0, data_addr, code_addr;
	logic [7:0]  boot_rdata, other_rdata, data_rdata;
	logic [2:0]  data_target, code_target;
	logic [10:0] boot_offset;
	int          mismatches = 0, cmp_count = 0;
	data_area_address_map u_dut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.data_addr     (data_addr),
		.code_addr     (code_addr),
		.boot_rdata    (boot_rdata),
		.other_rdata   (other_rdata),
		.data_target   (data_target),
		.code_target   (code_target),
		.boot_offset   (boot_offset),
		.data_rdata    (data_rdata),
		.boot_mapped   (boot_mapped)
	);
	cpu_core_model u_cpu (.aclk, .addr_req, .data_addr, .code_addr, .boot_rdata, .other_rdata);
	initial forever #5 aclk = ~aclk;
	task chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one write or read; each channel drops only on its own handshake, a hang ends the run
	task xfer(input logic wr, input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!(s_axi_bvalid | s_axi_rvalid) && n < 20);
		chk(s_axi_bvalid | s_axi_rvalid, 1);
		chk(wr ? s_axi_bresp : s_axi_rresp, r);
		if (!wr && r == 2'h0) chk(s_axi_rdata, d);
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (!(s_axi_bvalid | s_axi_rvalid)) summarize;
	endtask
	// decode answers one edge after the model presents the address
	task dec(input logic [15:0] a, input logic [2:0] t, ct, input logic [7:0] r);
		@(posedge aclk);
		addr_req <= a;
		repeat (2) @(posedge aclk);
		#1;
		chk(data_target, t);
		chk(code_target, ct);
		chk(data_rdata, r);
		chk(boot_offset, a[10:0]);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		xfer(0, 14'h3f40, 8'h40, 2'h0);
		dec(16'h1000, 3'h0, 3'h0, 8'hff);
		chk(boot_mapped, 1'b0);
		dec(16'h003f, 3'h1, 3'h0, 8'h00);
		dec(16'h0e40, 3'h1, 3'h0, 8'h0e);
		dec(16'h0f00, 3'h1, 3'h0, 8'h0f);
		dec(16'h0040, 3'h2, 3'h0, 8'h00);
		dec(16'h083f, 3'h2, 3'h0, 8'h08);
		dec(16'h8000, 3'h4, 3'h4, 8'h80);
		dec(16'hffff, 3'h4, 3'h4, 8'hff);
		$display("test reset map done");
		xfer(1, 14'h3f40, 8'h50, 2'h0);
		xfer(0, 14'h3f48, 8'h40, 2'h0);
		xfer(1, 14'h3f44, 8'h00, 2'h0);
		xfer(0, 14'h3f48, 8'h40, 2'h0);
		xfer(0, 14'h3f44, 8'h00, 2'h0);
		xfer(1, 14'h3f44, 8'hd5, 2'h0);
		xfer(0, 14'h3f48, 8'h50, 2'h0);
		s_axi_wstrb <= 4'h0;
		xfer(1, 14'h3f40, 8'h00, 2'h0);
		s_axi_wstrb <= 4'hf;
		xfer(0, 14'h3f40, 8'h50, 2'h0);
		xfer(1, 14'h3f4c, 8'h00, 2'h2); // unmapped
		xfer(0, 14'h3f41, 8'h00, 2'h2); // misaligned
		xfer(0, 14'h3f4c, 8'h00, 2'h2); // unmapped
		dec(16'h1000, 3'h3, 3'h3, 8'h5a);
		chk(boot_mapped, 1'b1);
		dec(16'h17ff, 3'h3, 3'h3, 8'ha5);
		dec(16'h1800, 3'h0, 3'h0, 8'h18);
		$display("test commit done");
		// second reset in mid-run must restore the default map
		@(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		xfer(0, 14'h3f48, 8'h40, 2'h0);
		xfer(0, 14'h3f40, 8'h40, 2'h0);
		dec(16'h1000, 3'h0, 3'h0, 8'hff);
		chk(boot_mapped, 1'b0);
		$display("test second reset done");
		summarize;
	end
endmodule

// ### hw/data_area_address_map.v
// data-area and code-area address decoder with double-buffered boot rom map control
// assumes the cpu core presents one data and one code address per cycle on aclk;
// registers reached over axi4-lite, byte address = 4 * register index
//
// Function
// - peripheral windows at three fixed data ranges
// - data 0x0040-0x083f goes to ram
// - ram not cleared; software initialises it
// - boot rom unmapped after reset
// - committed select maps boot rom both spaces
// - unmapped boot window reads 0xff
// - only lowest 2 kbytes reachable outside serial mode
// - control writes hold until commit key
// - readable register shows active copy
// - select is bit 4, resets zero
// - data 0x8000-0xffff goes to flash
// - code fetch 0x8000-0xffff goes to flash
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "data_area_address_map_consts.vh"

module data_area_address_map (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [13:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [13:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] data_addr,
	input  wire [15:0] code_addr,
	input  wire [7:0]  boot_rdata,
	input  wire [7:0]  other_rdata,
	output reg  [2:0]  data_target,
	output reg  [2:0]  code_target,
	output reg  [10:0] boot_offset,
	output reg  [7:0]  data_rdata,
	output reg         boot_mapped
);

	// holding stage and active copy of the map control
	reg  [7:0]  map_ctrl_q;
	reg  [7:0]  active_q;
	reg  [13:0] aw_addr_q;
	reg         aw_have_q;
	reg  [7:0]  w_data_q;
	reg         w_strb0_q;
	reg         w_have_q;
	reg  [2:0]  dtgt_d;
	reg  [2:0]  ctgt_d;
	reg  [11:0] rd_idx;
	wire        active_boot;
	wire [11:0] wr_idx;
	wire        do_write;
	// one hit flag per data-area region, decoded from the live cpu address
	wire        d_boot_hit;
	wire        d_pw_low_hit;
	wire        d_pw_mid_hit;
	wire        d_pw_high_hit;
	wire        d_ram_hit;
	wire        d_flash_hit;
	// code-area regions: only the boot window and flash are fetchable
	wire        c_boot_hit;
	wire        c_flash_hit;

	assign active_boot = active_q[`BOOT_SEL_BIT];
	assign wr_idx      = aw_addr_q[13:2];
	assign do_write    = aw_have_q && w_have_q && !s_axi_bvalid;

	// write address and data taken in either order, held until both present
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 14'h0000;
			w_data_q      <= 8'h00;
			w_strb0_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q  <= 1'b1;
				w_data_q  <= s_axi_wdata[7:0]; // only the low byte reaches a register
				w_strb0_q <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// unmapped or misaligned address answers slverr
				if (aw_addr_q[1:0] == 2'h0 &&
				    (wr_idx == `IDX_MAP_CTRL || wr_idx == `IDX_COMMIT))
					s_axi_bresp <= `RESP_OKAY;
				else
					s_axi_bresp <= `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control registers: holding stage written freely, active copy only on the key
	always @(posedge aclk) begin
		if (!aresetn) begin
			map_ctrl_q <= `MAP_CTRL_RESET;
			active_q   <= `MAP_CTRL_RESET;
		end else if (do_write && w_strb0_q && aw_addr_q[1:0] == 2'h0) begin
			if (wr_idx == `IDX_MAP_CTRL)
				map_ctrl_q <= w_data_q[7:0];
			// any other value leaves the active copy alone
			if (wr_idx == `IDX_COMMIT && w_data_q[7:0] == `COMMIT_KEY)
				active_q <= map_ctrl_q;
		end
	end

	// read channel: one read at a time, answer two cycles after arvalid
	always @* begin
		rd_idx = s_axi_araddr[13:2];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				s_axi_rdata  <= 32'h00000000;
				if (s_axi_araddr[1:0] != 2'h0)
					s_axi_rresp <= `RESP_SLVERR;
				else if (rd_idx == `IDX_MAP_CTRL)
					s_axi_rdata <= {24'h000000, map_ctrl_q};
				else if (rd_idx == `IDX_COMMIT)
					s_axi_rdata <= 32'h00000000; // write-only key
				else if (rd_idx == `IDX_READBACK)
					s_axi_rdata <= {24'h000000, active_q};
				else
					s_axi_rresp <= `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// data-area region comparators; each is one inclusive range of the cpu address
	addr_range_hit #(
		.LO (`BOOT_START),
		.HI (`BOOT_END)
	) u_d_boot (
		.addr (data_addr),
		.hit  (d_boot_hit)
	);
	addr_range_hit #(
		.LO (`PW_LOW_START),
		.HI (`PW_LOW_END)
	) u_d_pw_low (
		.addr (data_addr),
		.hit  (d_pw_low_hit)
	);
	addr_range_hit #(
		.LO (`PW_MID_START),
		.HI (`PW_MID_END)
	) u_d_pw_mid (
		.addr (data_addr),
		.hit  (d_pw_mid_hit)
	);
	addr_range_hit #(
		.LO (`PW_HIGH_START),
		.HI (`PW_HIGH_END)
	) u_d_pw_high (
		.addr (data_addr),
		.hit  (d_pw_high_hit)
	);
	addr_range_hit #(
		.LO (`RAM_START),
		.HI (`RAM_END)
	) u_d_ram (
		.addr (data_addr),
		.hit  (d_ram_hit)
	);
	addr_range_hit #(
		.LO (`FLASH_START),
		.HI (`FLASH_END)
	) u_d_flash (
		.addr (data_addr),
		.hit  (d_flash_hit)
	);

	// code-area comparators; fetches never reach peripherals or ram here
	addr_range_hit #(
		.LO (`BOOT_START),
		.HI (`BOOT_END)
	) u_c_boot (
		.addr (code_addr),
		.hit  (c_boot_hit)
	);
	addr_range_hit #(
		.LO (`FLASH_START),
		.HI (`FLASH_END)
	) u_c_flash (
		.addr (code_addr),
		.hit  (c_flash_hit)
	);

	// data-area decode; boot window checked first so exactly one target wins
	// the regions are disjoint today, the order only matters if one is widened
	always @* begin
		dtgt_d = `TGT_NONE;
		if (d_boot_hit)
			dtgt_d = active_boot ? `TGT_BOOT : `TGT_NONE;
		else if (d_pw_low_hit || d_pw_mid_hit || d_pw_high_hit)
			dtgt_d = `TGT_PERIPH;
		else if (d_ram_hit)
			dtgt_d = `TGT_RAM; // contents left as found
		else if (d_flash_hit)
			dtgt_d = `TGT_FLASH;
	end

	// code-area decode: boot rom when mapped, flash in the upper half
	always @* begin
		ctgt_d = `TGT_NONE;
		if (c_boot_hit && active_boot)
			ctgt_d = `TGT_BOOT;
		else if (c_flash_hit)
			ctgt_d = `TGT_FLASH;
	end

	// registered outputs; boot offset is 11 bits so only the lowest 2 kbytes are reachable
	always @(posedge aclk) begin
		if (!aresetn) begin
			data_target <= `TGT_NONE;
			code_target <= `TGT_NONE;
			boot_offset <= 11'h000;
			data_rdata  <= `UNMAPPED_BYTE;
			boot_mapped <= 1'b0;
		end else begin
			data_target <= dtgt_d;
			code_target <= ctgt_d;
			boot_offset <= data_addr[10:0];
			boot_mapped <= active_boot;
			if (d_boot_hit)
				data_rdata <= active_boot ? boot_rdata : `UNMAPPED_BYTE;
			else
				data_rdata <= other_rdata;
		end
	end

endmodule

// one inclusive address range compare; a bound at the end of the space is
// left out, so only a range spanning the whole space keeps a compare that is always true
module addr_range_hit #(
	parameter [15:0] LO = 16'h0000,
	parameter [15:0] HI = 16'hffff
) (
	input  wire [15:0] addr,
	output wire        hit
);

	// pick the compare form once, at elaboration
	generate
		if (LO == 16'h0000) begin : g_upper_only
			assign hit = (addr <= HI);
		end else if (HI == 16'hffff) begin : g_lower_only
			assign hit = (addr >= LO);
		end else begin : g_both
			assign hit = (addr >= LO) && (addr <= HI);
		end
	endgenerate

endmodule

// ### hw/data_area_address_map_consts.vh
// constants for the data-area address decoder
// assumes a 16-bit cpu address, 8-bit data and a 32-bit axi4-lite register port
`ifndef DATA_AREA_ADDRESS_MAP_CONSTS_VH
`define DATA_AREA_ADDRESS_MAP_CONSTS_VH
// peripheral windows
`define PW_LOW_START   16'h0000
`define PW_LOW_END     16'h003f
`define PW_HIGH_START  16'h0f00
`define PW_HIGH_END    16'h0fff
`define PW_MID_START   16'h0e40
`define PW_MID_END     16'h0eff
// ram, boot rom, flash
`define RAM_START      16'h0040
`define RAM_END        16'h083f
`define BOOT_START     16'h1000
`define BOOT_END       16'h17ff
`define FLASH_START    16'h8000
`define FLASH_END      16'hffff
`define UNMAPPED_BYTE  8'hff
// register indices (printed offsets are not multiples of four)
`define IDX_MAP_CTRL   12'hfd0
`define IDX_COMMIT     12'hfd1
`define IDX_READBACK   12'hfd2
`define MAP_CTRL_RESET 8'h40
`define BOOT_SEL_BIT   4
`define COMMIT_KEY     8'hd5
// target codes
`define TGT_NONE       3'h0
`define TGT_PERIPH     3'h1
`define TGT_RAM        3'h2
`define TGT_BOOT       3'h3
`define TGT_FLASH      3'h4
// axi responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif
